// File: verilog/clock_source_pkg.sv
// Constants, field layout and mode encoding for the clock source unit
// Overview of operation
// - Reset lands in engaged internal mode
// - Engaged external: loop on external reference
// - Bypassed internal: loop runs, system from internal
// - Internal low power: loop off, no debug
// - Bypassed external: loop runs, system from external
// - External low power: loop off, no debug
// - Stop: no loop, system, debug clocks
// - Source select picks source; code 11 acts 00
// - Reference divider divides by two to N
// - Reference select bit picks internal or external
// - Internal reference output gated by enable
// - Internal reference survives stop if enabled
// - Bus divider divides by 1, 2, 4, 8
// - Range bit picks crystal frequency range
// - Gain bit picks high gain or low power
// - Loop-off bit stops loop in bypass, except debug
// - Kind bit requests crystal or clock input
// - External reference output gated by enable
// - External reference survives stop if enabled
// - Loop locks at 512 times divided reference
// - Mode status lags through synchronisation
package clock_source_pkg;

  // Register byte addresses
  localparam logic [3:0] SRC_CTL_ADDR = 4'h0;
  localparam logic [3:0] BUS_CTL_ADDR = 4'h4;
  localparam logic [3:0] STATUS_ADDR  = 4'h8;

  // Reset values
  localparam logic [7:0] SRC_CTL_RESET = 8'h04;
  localparam logic [7:0] BUS_CTL_RESET = 8'h40;

  // Source control fields
  localparam int SRC_SEL_LSB     = 6;
  localparam int REF_DIV_LSB     = 3;
  localparam int REF_SEL_BIT     = 2;
  localparam int INT_OUT_EN_BIT  = 1;
  localparam int INT_STOP_EN_BIT = 0;

  // Bus divider and crystal control fields
  localparam int BUS_DIV_LSB     = 6;
  localparam int RANGE_BIT       = 5;
  localparam int GAIN_BIT        = 4;
  localparam int LOOP_OFF_BIT    = 3;
  localparam int EXT_KIND_BIT    = 2;
  localparam int EXT_OUT_EN_BIT  = 1;
  localparam int EXT_STOP_EN_BIT = 0;

  // Source select codes
  localparam logic [1:0] SRC_LOOP = 2'h0;
  localparam logic [1:0] SRC_INT  = 2'h1;
  localparam logic [1:0] SRC_EXT  = 2'h2;
  localparam logic [1:0] SRC_RSVD = 2'h3;

  // Loop lock ratio and counter width
  localparam int         LOOP_CNT_W = 11;
  localparam logic [10:0] LOOP_MULT = 11'h200;

  typedef enum logic [6:0] {
    MODE_ENG_INT        = 7'h01,
    MODE_ENG_EXT        = 7'h02,
    MODE_BYP_INT        = 7'h04,
    MODE_BYP_INT_LOWPWR = 7'h08,
    MODE_BYP_EXT        = 7'h10,
    MODE_BYP_EXT_LOWPWR = 7'h20,
    MODE_STOP           = 7'h40
  } mode_t;

endpackage

// File: verilog/pow2_divider.sv
// Tick divider by two raised to a selectable power
`timescale 1ns/1ps
module pow2_divider
  import clock_source_pkg::*;
#(
  parameter int SEL_W = 3
)
(
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // Tick stream
  input  wire logic             tick_in,
  input  wire logic [SEL_W-1:0] sel_in,
  output logic                  tick_out
);
  localparam int CNT_W = (1 << SEL_W) - 1;

  logic [CNT_W-1:0] count_reg;
  wire  [CNT_W-1:0] mask = CNT_W'((1 << sel_in) - 1);
  wire              wrap = tick_in && ((count_reg & mask) == mask);

  // Free counter of input ticks; output on every 2^sel-th tick
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count_reg <= '0;
      tick_out  <= 1'b0;
    end
    else
    begin
      if (tick_in)
        count_reg <= count_reg + 1'b1;
      tick_out <= wrap;
    end
  end
endmodule

// File: verilog/clock_source_unit.sv
// Clock source unit: mode control, loop control, dividers, register slave
//
// Added by the designer: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module clock_source_unit
  import clock_source_pkg::*;
#(
  parameter int TRIM_W = 9
)
(
  // Clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              rst_n_in,
  // Avalon-MM slave
  input  wire logic [3:0]        avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic      [31:0]       avs_readdata_out,
  output logic                   avs_waitrequest_out,
  // Chip state
  input  wire logic              stop_in,
  input  wire logic              debug_active_in,
  // Raw clock ticks from the oscillators
  input  wire logic              int_ref_tick_in,
  input  wire logic              ext_ref_tick_in,
  input  wire logic              loop_tick_in,
  // Clock outputs and enables
  output logic                   system_clock_enable_out,
  output logic                   system_tick_out,
  output logic                   bus_tick_out,
  output logic                   debug_clock_enable_out,
  // Loop control
  output logic                   loop_enable_out,
  output logic                   loop_ref_internal_out,
  output logic      [TRIM_W-1:0] loop_trim_out,
  // Reference outputs
  output logic                   internal_ref_enable_out,
  output logic                   internal_ref_clock_out,
  output logic                   external_ref_enable_out,
  output logic                   external_ref_clock_out,
  // Crystal control
  output logic                   crystal_request_out,
  output logic                   crystal_high_range_out,
  output logic                   crystal_high_gain_out
);

  // Mode from source select, reference select, loop-off and debug state
  function automatic mode_t decode_mode(input logic [1:0] src, input logic ref_int,
                                        input logic loop_off, input logic dbg);
    logic lowpwr;
    lowpwr = loop_off && !dbg;
    if (src == SRC_INT)
      decode_mode = lowpwr ? MODE_BYP_INT_LOWPWR : MODE_BYP_INT;
    else if (src == SRC_EXT)
      decode_mode = lowpwr ? MODE_BYP_EXT_LOWPWR : MODE_BYP_EXT;
    else
      decode_mode = ref_int ? MODE_ENG_INT : MODE_ENG_EXT;
  endfunction

  function automatic logic uses_internal(input mode_t m);
    uses_internal = (m == MODE_ENG_INT) || (m == MODE_BYP_INT) ||
                    (m == MODE_BYP_INT_LOWPWR);
  endfunction

  function automatic logic uses_external(input mode_t m);
    uses_external = (m == MODE_ENG_EXT) || (m == MODE_BYP_EXT) ||
                    (m == MODE_BYP_EXT_LOWPWR);
  endfunction

  // Reset release through two flip-flops
  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire rst_n = rst_sync_reg;

  logic [7:0]            src_ctl_reg;
  logic [7:0]            bus_ctl_reg;
  mode_t                 mode_reg;
  mode_t                 last_run_reg;
  logic [1:0]            status_meta_reg;
  logic [1:0]            status_reg;
  logic [LOOP_CNT_W-1:0] loop_cnt_reg;
  logic                  filter_tick;

  // Register fields
  wire [1:0] source_select       = src_ctl_reg[SRC_SEL_LSB +: 2];
  wire [2:0] reference_divider   = src_ctl_reg[REF_DIV_LSB +: 3];
  wire       reference_select    = src_ctl_reg[REF_SEL_BIT];
  wire       int_out_en          = src_ctl_reg[INT_OUT_EN_BIT];
  wire       int_stop_en         = src_ctl_reg[INT_STOP_EN_BIT];
  wire [1:0] bus_divider         = bus_ctl_reg[BUS_DIV_LSB +: 2];
  wire       bypass_loop_off     = bus_ctl_reg[LOOP_OFF_BIT];
  wire       external_ref_kind   = bus_ctl_reg[EXT_KIND_BIT];
  wire       ext_out_en          = bus_ctl_reg[EXT_OUT_EN_BIT];
  wire       ext_stop_en         = bus_ctl_reg[EXT_STOP_EN_BIT];

  // Bus request decode
  wire bus_req   = avs_read_in || avs_write_in;
  wire bus_done  = bus_req && !avs_waitrequest_out;
  wire wr_accept = bus_done && avs_write_in && avs_byteenable_in[0];
  wire wr_src    = wr_accept && (avs_address_in == SRC_CTL_ADDR);
  wire wr_bus    = wr_accept && (avs_address_in == BUS_CTL_ADDR);

  // Read selection; unmapped addresses read zero
  wire [7:0] rd_byte;
  assign rd_byte = (avs_address_in == SRC_CTL_ADDR) ? src_ctl_reg :
                   (avs_address_in == BUS_CTL_ADDR) ? bus_ctl_reg :
                   (avs_address_in == STATUS_ADDR)  ? {6'h00, status_reg} : 8'h00;

  // One wait cycle per request, then registers and read data update
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
      src_ctl_reg         <= SRC_CTL_RESET;
      bus_ctl_reg         <= BUS_CTL_RESET;
    end
    else
    begin
      avs_waitrequest_out <= !(bus_req && avs_waitrequest_out);
      if (bus_req && avs_waitrequest_out)
        avs_readdata_out <= {24'h00_0000, rd_byte};
      if (wr_src)
        src_ctl_reg <= avs_writedata_in[7:0];
      if (wr_bus)
        bus_ctl_reg <= avs_writedata_in[7:0];
    end
  end

  // Operating mode; stop overrides everything
  mode_t mode_next;
  assign mode_next = stop_in ? MODE_STOP :
                     decode_mode(source_select, reference_select,
                                 bypass_loop_off, debug_active_in);

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg     <= MODE_ENG_INT;
      last_run_reg <= MODE_ENG_INT;
    end
    else
    begin
      mode_reg <= mode_next;
      if (mode_reg != MODE_STOP)
        last_run_reg <= mode_reg;
    end
  end

  // Per-mode clock decisions
  logic       loop_on;
  logic       sys_on;
  logic [1:0] mode_code;
  always_comb
  begin
    loop_on   = 1'b0;
    sys_on    = 1'b1;
    mode_code = SRC_LOOP;
    case (mode_reg)
      MODE_ENG_INT:        loop_on = 1'b1;
      MODE_ENG_EXT:        loop_on = 1'b1;
      MODE_BYP_INT:
      begin
        loop_on   = 1'b1;
        mode_code = SRC_INT;
      end
      MODE_BYP_INT_LOWPWR: mode_code = SRC_INT;
      MODE_BYP_EXT:
      begin
        loop_on   = 1'b1;
        mode_code = SRC_EXT;
      end
      MODE_BYP_EXT_LOWPWR: mode_code = SRC_EXT;
      MODE_STOP:           sys_on = 1'b0;
      default:             sys_on = 1'b0;
    endcase
  end

  // Reference oscillators: kept while used or enabled; in stop only by stop enable
  wire in_stop = (mode_reg == MODE_STOP);
  wire int_on  = in_stop ? (int_stop_en && (int_out_en || uses_internal(last_run_reg)))
                         : (int_out_en || uses_internal(mode_reg) ||
                            (loop_on && reference_select));
  wire ext_on  = in_stop ? (ext_stop_en && (ext_out_en || uses_external(last_run_reg)))
                         : (ext_out_en || uses_external(mode_reg) ||
                            (loop_on && !reference_select));

  // Gated ticks
  wire int_tick  = int_ref_tick_in && internal_ref_enable_out;
  wire ext_tick  = ext_ref_tick_in && external_ref_enable_out;
  wire loop_ref  = loop_enable_out && (reference_select ? int_tick : ext_tick);
  wire sys_tick  = !system_clock_enable_out    ? 1'b0 :
                   (mode_code == SRC_INT)      ? int_tick :
                   (mode_code == SRC_EXT)      ? ext_tick : loop_tick_in;

  // Loop reference divider
  pow2_divider #(.SEL_W(3)) ref_div_u
  (
    .clk_in   (ref_clk_in),
    .rst_n_in (rst_n),
    .tick_in  (loop_ref),
    .sel_in   (reference_divider),
    .tick_out (filter_tick)
  );

  // Bus clock divider on the selected system ticks
  pow2_divider #(.SEL_W(2)) bus_div_u
  (
    .clk_in   (ref_clk_in),
    .rst_n_in (rst_n),
    .tick_in  (system_tick_out),
    .sel_in   (bus_divider),
    .tick_out (bus_tick_out)
  );

  // Frequency lock: loop ticks per divided reference period against the ratio
  wire cnt_full  = (loop_cnt_reg == {LOOP_CNT_W{1'b1}});
  wire trim_max  = (loop_trim_out == {TRIM_W{1'b1}});
  wire trim_min  = (loop_trim_out == '0);
  wire too_slow  = filter_tick && (loop_cnt_reg < LOOP_MULT) && !trim_max;
  wire too_fast  = filter_tick && (loop_cnt_reg > LOOP_MULT) && !trim_min;

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loop_cnt_reg  <= '0;
      loop_trim_out <= '0;
    end
    else if (!loop_enable_out)
      loop_cnt_reg <= '0;
    else
    begin
      if (filter_tick)
        loop_cnt_reg <= LOOP_CNT_W'(loop_tick_in);
      else if (loop_tick_in && !cnt_full)
        loop_cnt_reg <= loop_cnt_reg + 1'b1;
      if (too_slow)
        loop_trim_out <= loop_trim_out + 1'b1;
      else if (too_fast)
        loop_trim_out <= loop_trim_out - 1'b1;
    end
  end

  // Registered clock control outputs
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      system_clock_enable_out <= 1'b1;
      system_tick_out         <= 1'b0;
      debug_clock_enable_out  <= 1'b1;
      loop_enable_out         <= 1'b1;
      loop_ref_internal_out   <= 1'b1;
      internal_ref_enable_out <= 1'b1;
      internal_ref_clock_out  <= 1'b0;
      external_ref_enable_out <= 1'b0;
      external_ref_clock_out  <= 1'b0;
      crystal_request_out     <= 1'b0;
      crystal_high_range_out  <= 1'b0;
      crystal_high_gain_out   <= 1'b0;
    end
    else
    begin
      system_clock_enable_out <= sys_on;
      system_tick_out         <= sys_tick;
      debug_clock_enable_out  <= loop_on;
      loop_enable_out         <= loop_on;
      loop_ref_internal_out   <= reference_select;
      internal_ref_enable_out <= int_on;
      internal_ref_clock_out  <= int_tick && int_out_en;
      external_ref_enable_out <= ext_on;
      external_ref_clock_out  <= ext_tick && ext_out_en;
      crystal_request_out     <= ext_on && external_ref_kind;
      crystal_high_range_out  <= bus_ctl_reg[RANGE_BIT];
      crystal_high_gain_out   <= bus_ctl_reg[GAIN_BIT];
    end
  end

  // Mode status through a two-stage synchroniser
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_meta_reg <= SRC_LOOP;
      status_reg      <= SRC_LOOP;
    end
    else
    begin
      status_meta_reg <= mode_code;
      status_reg      <= status_meta_reg;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n);

  sequence code_steady;
    (mode_code == $past(mode_code))[*3];
  endsequence

  sequence lowpwr_internal_req;
    !stop_in && bypass_loop_off && !debug_active_in && (source_select == SRC_INT);
  endsequence

  reset_mode_a: assert property (
    (src_ctl_reg == SRC_CTL_RESET && !stop_in) |=> (mode_reg == MODE_ENG_INT))
    else $error("reset configuration not in engaged internal mode");

  reserved_src_a: assert property (
    (source_select == SRC_RSVD && reference_select && !stop_in)
    |=> ##1 (loop_enable_out && debug_clock_enable_out))
    else $error("reserved source code not treated as loop output");

  loop_off_a: assert property (
    lowpwr_internal_req |=> ##1 (!loop_enable_out && !debug_clock_enable_out))
    else $error("loop still running in low power bypass");

  debug_keeps_a: assert property (
    (!stop_in && bypass_loop_off && debug_active_in && source_select == SRC_EXT)
    |=> ##1 loop_enable_out)
    else $error("loop stopped while debug active");

  stop_clocks_a: assert property (
    stop_in [*2] |=> (!system_clock_enable_out && !loop_enable_out &&
                      !debug_clock_enable_out))
    else $error("clocks running in stop");

  int_gate_a: assert property (
    !int_out_en [*2] |-> !internal_ref_clock_out)
    else $error("internal reference output while disabled");

  ext_stop_a: assert property (
    (in_stop && !ext_stop_en) |=> !external_ref_enable_out)
    else $error("external reference running in stop without enable");

  status_lag_a: assert property (
    code_steady |-> (status_reg == mode_code))
    else $error("mode status not settled after synchroniser");

  trim_up_a: assert property (
    too_slow && loop_enable_out |=> (loop_trim_out == $past(loop_trim_out) + 1'b1))
    else $error("loop trim did not rise on slow count");

  wait_cycle_a: assert property (
    (bus_req && avs_waitrequest_out) |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("wait state sequence broken");

endmodule

// File: bench/osc_model.sv
// Behavioural oscillators feeding the clock source unit
`timescale 1ns/1ps
module osc_model
#(
  parameter int INT_PER = 4,
  parameter int EXT_PER = 6,
  parameter int STARTUP = 16
)
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Enables from the unit
  input  wire logic int_en_in,
  input  wire logic ext_en_in,
  input  wire logic loop_en_in,
  input  wire logic xtal_req_in,
  // Oscillator ticks
  output logic      int_tick_out,
  output logic      ext_tick_out,
  output logic      loop_tick_out
);
  int int_cnt;
  int ext_cnt;
  int start_cnt;

  // Ticks only while enabled; crystal needs a start-up delay
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      int_cnt <= 0;
      ext_cnt <= 0;
      start_cnt <= 0;
      int_tick_out <= 1'b0;
      ext_tick_out <= 1'b0;
      loop_tick_out <= 1'b0;
    end
    else
    begin
      int_cnt <= (int_cnt + 1) % INT_PER;
      ext_cnt <= (ext_cnt + 1) % EXT_PER;
      start_cnt <= !xtal_req_in ? 0 : (start_cnt < STARTUP) ? start_cnt + 1 : start_cnt;
      int_tick_out <= int_en_in && (int_cnt == 0);
      ext_tick_out <= ext_en_in && (ext_cnt == 0) && (!xtal_req_in || start_cnt == STARTUP);
      loop_tick_out <= loop_en_in; // Loop runs at full rate
    end
  end
endmodule

// File: bench/tb.sv
// Self-checking bench for the clock source unit
`timescale 1ns/1ps
module tb;
  import clock_source_pkg::*;
  typedef struct packed {
    logic [7:0] src;
    logic [7:0] bus;
    logic       stp;
    logic       dbg;
    logic [8:0] exp;
  } row_t;
  // Expected: sys, loop, debug, ref internal, int on, ext on, crystal, range, gain
  localparam row_t ROWS [17] = '{
    '{8'h06, 8'h40, 1'h0, 1'h0, 9'h1f0},
    '{8'h00, 8'h40, 1'h0, 1'h0, 9'h1c8},
    '{8'h00, 8'h44, 1'h0, 1'h0, 9'h1cc},
    '{8'h44, 8'h48, 1'h0, 1'h1, 9'h1f0},
    '{8'h44, 8'h40, 1'h0, 1'h0, 9'h1f0},
    '{8'h44, 8'h48, 1'h0, 1'h0, 9'h130},
    '{8'h80, 8'h40, 1'h0, 1'h0, 9'h1c8},
    '{8'h80, 8'h48, 1'h0, 1'h0, 9'h108},
    '{8'h80, 8'h48, 1'h0, 1'h1, 9'h1c8},
    '{8'hc4, 8'h48, 1'h0, 1'h0, 9'h1f0},
    '{8'h04, 8'h72, 1'h0, 1'h0, 9'h1fb},
    '{8'h04, 8'h76, 1'h0, 1'h0, 9'h1ff},
    '{8'h05, 8'h40, 1'h1, 1'h0, 9'h030},
    '{8'h04, 8'h40, 1'h1, 1'h0, 9'h020},
    '{8'h04, 8'h43, 1'h1, 1'h0, 9'h028},
    '{8'h04, 8'h42, 1'h1, 1'h0, 9'h020},
    '{8'h80, 8'h40, 1'h0, 1'h0, 9'h1c8}
  };
  logic        clk, rst_n, rd, wr, stp, dbg, it, et, lt;
  logic [3:0]  addr, ben;
  logic [31:0] wdata, rdata, d;
  logic        wait_r, sys_en, sys_t, bus_t, dbg_en, loop_en, ref_int;
  logic        int_en, int_clk, ext_en, ext_clk, xreq, hrange, hgain;
  logic [8:0]  trim;
  logic [9:0]  t0, dd;
  int          mismatches, checks_done, sc, bc, ic, ec;

  // Clock at 250 MHz
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  clock_source_unit u_dut (
    .ref_clk_in(clk), .rst_n_in(rst_n), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(ben),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_r), .stop_in(stp),
    .debug_active_in(dbg), .int_ref_tick_in(it), .ext_ref_tick_in(et), .loop_tick_in(lt),
    .system_clock_enable_out(sys_en), .system_tick_out(sys_t), .bus_tick_out(bus_t),
    .debug_clock_enable_out(dbg_en), .loop_enable_out(loop_en),
    .loop_ref_internal_out(ref_int), .loop_trim_out(trim),
    .internal_ref_enable_out(int_en), .internal_ref_clock_out(int_clk),
    .external_ref_enable_out(ext_en), .external_ref_clock_out(ext_clk),
    .crystal_request_out(xreq), .crystal_high_range_out(hrange),
    .crystal_high_gain_out(hgain));

  osc_model u_osc (
    .clk_in(clk), .rst_n_in(rst_n), .int_en_in(int_en), .ext_en_in(ext_en),
    .loop_en_in(loop_en), .xtal_req_in(xreq), .int_tick_out(it), .ext_tick_out(et),
    .loop_tick_out(lt));

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One Avalon cycle, held until waitrequest is sampled low
  task automatic av_cycle(input logic w, input logic [3:0] a, input logic [7:0] v,
                          input logic [3:0] be);
    int   k;
    logic seen;
    @(posedge clk);
    addr <= a;
    wdata <= {24'h000000, v};
    ben <= be;
    wr <= w;
    rd <= !w;
    k = 0;
    do
    begin
      // Settled answer sampled mid-cycle; the next rising edge completes it
      @(negedge clk);
      seen = wait_r;
      d = rdata;
      k++;
      if (k > 20)
      begin
        mismatches++;
        summarize();
      end
      @(posedge clk);
    end while (seen !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic count(input int n);
    sc = 0;
    bc = 0;
    ic = 0;
    ec = 0;
    repeat (n)
    begin
      @(posedge clk);
      sc += (sys_t === 1'b1);
      bc += (bus_t === 1'b1);
      ic += (int_clk === 1'b1);
      ec += (ext_clk === 1'b1);
    end
  endtask

  // Main sequence
  initial
  begin
    mismatches = 0;
    checks_done = 0;
    {rst_n, rd, wr, stp, dbg, addr, ben, wdata} = '0;
    repeat (6) @(posedge clk);
    check({wait_r, sys_en, loop_en, dbg_en}, 4'hf);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check({sys_en, loop_en, dbg_en, ref_int}, 4'hf);
    av_cycle(1'b0, SRC_CTL_ADDR, 8'h00, 4'h1);
    check(d, 32'h04);
    av_cycle(1'b0, BUS_CTL_ADDR, 8'h00, 4'h1);
    check(d, 32'h40);
    av_cycle(1'b1, 4'hc, 8'hff, 4'hf);
    av_cycle(1'b1, SRC_CTL_ADDR, 8'hff, 4'h0);
    av_cycle(1'b0, 4'hc, 8'h00, 4'h1);
    check(d, 32'h0);
    av_cycle(1'b0, SRC_CTL_ADDR, 8'h00, 4'h1);
    check(d, 32'h04);
    // Mode table
    foreach (ROWS[i])
    begin
      av_cycle(1'b1, SRC_CTL_ADDR, ROWS[i].src, 4'h1);
      av_cycle(1'b1, BUS_CTL_ADDR, ROWS[i].bus, 4'h1);
      av_cycle(1'b0, SRC_CTL_ADDR, 8'h00, 4'h1);
      check(d, {24'h0, ROWS[i].src});
      @(posedge clk);
      stp <= ROWS[i].stp;
      dbg <= ROWS[i].dbg;
      repeat (6) @(posedge clk);
      check({sys_en, loop_en, dbg_en, ref_int, int_en, ext_en, xreq, hrange, hgain},
            ROWS[i].exp);
      count(40);
      check(sc != 0, ROWS[i].exp[8]);
      check(ic != 0, ROWS[i].src[1] & ROWS[i].exp[4]);
      check(ec != 0, ROWS[i].bus[1] & ROWS[i].exp[3]);
    end
    // Status follows the active source and ignores writes
    av_cycle(1'b0, STATUS_ADDR, 8'h00, 4'h1);
    check(d[1:0], SRC_EXT);
    av_cycle(1'b1, SRC_CTL_ADDR, 8'h44, 4'h1);
    av_cycle(1'b1, STATUS_ADDR, 8'h00, 4'h1);
    repeat (8) @(posedge clk);
    av_cycle(1'b0, STATUS_ADDR, 8'h00, 4'h1);
    check(d[1:0], SRC_INT);
    // Bus divider codes on the internal reference, loop parked so trim keeps headroom
    for (int c = 0; c < 4; c++)
    begin
      av_cycle(1'b1, BUS_CTL_ADDR, 8'(c << BUS_DIV_LSB) | 8'(1 << LOOP_OFF_BIT), 4'h1);
      repeat (8) @(posedge clk);
      count(256);
      check((bc << c) <= sc + (1 << c) && sc <= (bc << c) + (1 << c), 1'b1);
    end
    // Loop trim: below lock it climbs once per divided tick, at lock it holds
    av_cycle(1'b1, SRC_CTL_ADDR, 8'h34, 4'h1);
    repeat (300) @(posedge clk);
    t0 = {1'b0, trim};
    repeat (4096) @(posedge clk);
    dd = {1'b0, trim} - t0;
    check(dd >= 10'h00f && dd <= 10'h011, 1'b1);
    av_cycle(1'b1, SRC_CTL_ADDR, 8'h3c, 4'h1);
    repeat (600) @(posedge clk);
    t0 = {1'b0, trim};
    repeat (2048) @(posedge clk);
    dd = {1'b0, trim} - t0;
    check(dd == 10'h000 || dd == 10'h001 || dd == 10'h3ff, 1'b1);
    // Mid-run reset restores engaged internal mode and register defaults
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check({sys_en, loop_en, dbg_en, ref_int, int_en, ext_en, xreq}, 7'h7c);
    check(trim, 9'h000);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    av_cycle(1'b0, SRC_CTL_ADDR, 8'h00, 4'h1);
    check(d, 32'h04);
    av_cycle(1'b0, BUS_CTL_ADDR, 8'h00, 4'h1);
    check(d, 32'h40);
    summarize();
  end
endmodule
